// file: verilog/radio_core_irq_time_addr_regs.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "radio_regs_cfg.svh"

// Operation
// - Bit 9 shows pending software interrupt, masked at reset.
// - Bit 8 shows pending end-of-event/prefetch abort.
// - Bits 7,6 show fine/gross target timer.
// - Bits 5,4 show error and cipher done.
// - Bits 3,2 show end-of-event and end-of-sleep.
// - Bits 1,0 show packet receive and slot tick.
// - Writing one acknowledges, clearing raw and masked.
// - Acknowledge bits sit at raw status positions.
// - Acknowledge bits self-clear; reads return zero.
// - Ack bits 8,7,6 clear their matching flags.
// - Ack bits 4,2,1,0 clear their matching flags.
// - Slot counter snapshot at bits 26:0.
// - Microsecond counter snapshot at bits 9:0.
// - Sample trigger write refreshes both snapshots.
// - Lower 32 address bits, read-write, reset zero.
// - Upper 16 address bits at 15:0.
// - Privacy flag at bit 16, one means private.
// - Exchange table start at bits 31:16.
// - Receive descriptor list start at 14:0.
// - Masked status equals raw gated by mask.
// - Interrupt output is a level until acknowledged or masked.
module radio_core_irq_time_addr_regs #(
  parameter int IRQ_W  = `IRQ_W,
  parameter int SLOT_W = `SLOT_W,
  parameter int FINE_W = `FINE_W
) (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire radio_regs_pkg::reg_req_t req,
  output logic [31:0]                 rdata,
  input  wire radio_regs_pkg::irq_vec_t irq_events,
  input  wire logic [SLOT_W-1:0]      slot_counter_value,
  input  wire logic [FINE_W-1:0]      microsecond_counter_value,
  output radio_regs_pkg::irq_vec_t    irq_raw,
  output logic                        irq,
  output radio_regs_pkg::link_cfg_t   link_cfg
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [31:0] a,
                               input logic [31:0] ofs);
    hit = (a == ofs);
  endfunction

  logic                  wr_ack;
  logic                  wr_mask;
  logic                  wr_ctrl;
  logic                  wr_lo;
  logic                  wr_hi;
  logic                  wr_ptr;
  logic [IRQ_W-1:0]      raw_reg;
  logic [IRQ_W-1:0]      raw_next;
  logic [IRQ_W-1:0]      mask_reg;
  logic [IRQ_W-1:0]      ack_pulse;
  logic [SLOT_W-1:0]     slot_snap_reg;
  logic [FINE_W-1:0]     fine_snap_reg;
  logic [31:0]           addr_lo_reg;
  logic [15:0]           addr_hi_reg;
  logic                  priv_reg;
  logic [15:0]           xchg_reg;
  logic [14:0]           rxdesc_reg;
  logic [31:0]           rd_next;

  assign wr_ack  = req.wr && hit(req.addr, `OFS_IRQ_ACK);
  assign wr_mask = req.wr && hit(req.addr, `OFS_IRQ_MASK);
  assign wr_ctrl = req.wr && hit(req.addr, `OFS_CONTROL);
  assign wr_lo   = req.wr && hit(req.addr, `OFS_ADDR_LOW);
  assign wr_hi   = req.wr && hit(req.addr, `OFS_ADDR_HIGH);
  assign wr_ptr  = req.wr && hit(req.addr, `OFS_DESC_PTRS);

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  // The acknowledge is a pulse, not storage, so it is zero again
  // once the clear has acted and reads of it return zero.
  assign ack_pulse = wr_ack ? req.wdata[IRQ_W-1:0]
                            : {IRQ_W{1'b0}};

  // A source raised in the cycle of its acknowledge stays pending.
  always_comb begin
    raw_next = (raw_reg & ~ack_pulse)
             | irq_events;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      raw_reg <= {IRQ_W{1'b0}};
    end else begin
      raw_reg <= raw_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mask_reg <= `IRQ_MASK_RST;
    end else if (wr_mask) begin
      mask_reg <= req.wdata[IRQ_W-1:0];
    end
  end

  // Raw flags ignore the mask entirely.
  assign irq_raw = raw_reg;
  // Level output: it falls when the flag is acknowledged or its mask bit is cleared.
  assign irq = |(raw_reg & mask_reg);

  // ----------------------------------------------------------------
  // Counter snapshots
  // ----------------------------------------------------------------
  // Live counters move every microsecond, so software reads a held
  // copy taken on its own trigger rather than a moving value.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      slot_snap_reg <= {SLOT_W{1'b0}};
      fine_snap_reg <= {FINE_W{1'b0}};
    end else if (wr_ctrl && req.wdata[`SAMPLE_BIT]) begin
      slot_snap_reg <= slot_counter_value;
      fine_snap_reg <= microsecond_counter_value;
    end
  end

  // ----------------------------------------------------------------
  // Address and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      addr_lo_reg <= `ZERO_RST;
    end else if (wr_lo) begin
      addr_lo_reg <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      addr_hi_reg <= 16'h0000;
      priv_reg    <= 1'b0;
    end else if (wr_hi) begin
      addr_hi_reg <= req.wdata[`ADDR_HI_W-1:0];
      priv_reg    <= req.wdata[`PRIV_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      xchg_reg   <= 16'h0000;
      rxdesc_reg <= 15'h0000;
    end else if (wr_ptr) begin
      xchg_reg   <= req.wdata[`XCHG_LSB +: `XCHG_W];
      rxdesc_reg <= req.wdata[`RXDESC_W-1:0];
    end
  end

  assign link_cfg.device_addr              = {addr_hi_reg, addr_lo_reg};
  assign link_cfg.private_address_flag     = priv_reg;
  assign link_cfg.exchange_table_start     = xchg_reg;
  assign link_cfg.rx_descriptor_list_start = rxdesc_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_next = 32'h0000_0000;
    case (req.addr)
      `OFS_IRQ_MASK:   rd_next[IRQ_W-1:0]  = mask_reg;
      `OFS_IRQ_MASKED: rd_next[IRQ_W-1:0]  = raw_reg & mask_reg;
      `OFS_IRQ_RAW:    rd_next[IRQ_W-1:0]  = raw_reg;
      `OFS_BASE_SNAP:  rd_next[SLOT_W-1:0] = slot_snap_reg;
      `OFS_FINE_SNAP:  rd_next[FINE_W-1:0] = fine_snap_reg;
      `OFS_ADDR_LOW:   rd_next             = addr_lo_reg;
      `OFS_ADDR_HIGH:  rd_next             = {15'h0000, priv_reg,
                                              addr_hi_reg};
      `OFS_DESC_PTRS:  rd_next             = {xchg_reg, 1'b0,
                                              rxdesc_reg};
      default:         rd_next             = 32'h0000_0000;
    endcase
  end

  // Data stand for exactly the cycle after the read strobe.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata <= 32'h0000_0000;
    end else if (req.rd) begin
      rdata <= rd_next;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// file: verilog/radio_regs_cfg.svh
`ifndef RADIO_REGS_CFG_SVH
`define RADIO_REGS_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define OFS_CONTROL      32'h4000_0000
`define OFS_IRQ_MASK     32'h4000_000C
`define OFS_IRQ_MASKED   32'h4000_0010
`define OFS_IRQ_RAW      32'h4000_0014
`define OFS_IRQ_ACK      32'h4000_0018
`define OFS_BASE_SNAP    32'h4000_001C
`define OFS_FINE_SNAP    32'h4000_0020
`define OFS_ADDR_LOW     32'h4000_0024
`define OFS_ADDR_HIGH    32'h4000_0028
`define OFS_DESC_PTRS    32'h4000_002C

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define IRQ_W            10
`define SLOT_W           27
`define FINE_W           10
`define ADDR_HI_W        16
`define PRIV_BIT         16
`define SAMPLE_BIT       0
`define XCHG_LSB         16
`define XCHG_W           16
`define RXDESC_W         15

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IRQ_MASK_RST     10'h11F
`define ZERO_RST         32'h0000_0000

`endif

// file: verilog/radio_regs_pkg.sv
package radio_regs_pkg;

  // ----------------------------------------------------------------
  // One flag per interrupt source, bit 9 down to bit 0.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic soft_irq;
    logic event_prefetch_abort;
    logic fine_target_timer;
    logic gross_target_timer;
    logic error_irq;
    logic cipher_done;
    logic end_of_event;
    logic end_of_sleep;
    logic packet_rx;
    logic slot_tick;
  } irq_vec_t;

  // ----------------------------------------------------------------
  // Register port request.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // ----------------------------------------------------------------
  // Address and pointer settings handed to the link core.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [47:0] device_addr;
    logic        private_address_flag;
    logic [15:0] exchange_table_start;
    logic [14:0] rx_descriptor_list_start;
  } link_cfg_t;

endpackage

// file: tb/radio_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "radio_regs_cfg.svh"
module radio_regs_asserts #(
  parameter int SLOT_W = `SLOT_W,
  parameter int FINE_W = `FINE_W
) (
  input wire logic                      clk_sys,
  input wire logic                      srst,
  input wire radio_regs_pkg::reg_req_t  req,
  input wire logic [31:0]               rdata,
  input wire radio_regs_pkg::irq_vec_t  irq_events,
  input wire logic [SLOT_W-1:0]         slot_counter_value,
  input wire logic [FINE_W-1:0]         microsecond_counter_value,
  input wire radio_regs_pkg::irq_vec_t  irq_raw,
  input wire logic                      irq,
  input wire radio_regs_pkg::link_cfg_t link_cfg
);
  // ----------------------------------------------------------------
  // Port checks
  // ----------------------------------------------------------------
  logic [9:0] ack_hit;
  assign ack_hit = (req.wr && req.addr == `OFS_IRQ_ACK) ? req.wdata[9:0]
                                                         : 10'h000;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_wr(a); req.wr && req.addr == a; endsequence
  sequence s_rd(a); req.rd && req.addr == a; endsequence
  sequence s_samp; req.wr && req.addr == `OFS_CONTROL && req.wdata[0];
  endsequence
  AST_SET:
    assert property (!$past(srst) |-> (irq_raw & $past(irq_events))
      == $past(irq_events)) else $error("raw flag not set");
  AST_ACK:
    assert property (ack_hit != 10'h000 |=> (irq_raw & $past(ack_hit)
      & ~$past(irq_events)) == 10'h000) else $error("ack missed");
  AST_HOLD:
    assert property (!$past(srst) |-> ($past(irq_raw) & ~irq_raw
      & ~$past(ack_hit)) == 10'h000) else $error("flag lost");
  AST_RD_RAW:
    assert property (s_rd(`OFS_IRQ_RAW) |=>
      rdata == {22'h000000, $past(irq_raw)}) else $error("raw read");
  AST_RD_ACK:
    assert property (s_rd(`OFS_IRQ_ACK) |=> rdata == 32'h0000_0000)
      else $error("ack read");
  AST_LOW:
    assert property (s_wr(`OFS_ADDR_LOW) |=> link_cfg.device_addr[31:0]
      == $past(req.wdata)) else $error("addr low");
  AST_HIGH:
    assert property (s_wr(`OFS_ADDR_HIGH) |=> {link_cfg.private_address_flag,
      link_cfg.device_addr[47:32]} == $past(req.wdata[16:0]))
      else $error("addr high");
  AST_PTR:
    assert property (s_wr(`OFS_DESC_PTRS) |=> link_cfg.
      rx_descriptor_list_start == $past(req.wdata[14:0])) else $error("ptr");
  AST_SNAP:
    assert property (s_samp ##2 s_rd(`OFS_BASE_SNAP) |=> rdata[SLOT_W-1:0]
      == $past(slot_counter_value, 3)) else $error("snapshot");
  AST_IRQ:
    assert property (irq_raw == 10'h000 |-> !irq) else $error("idle irq");
endmodule
bind radio_core_irq_time_addr_regs radio_regs_asserts #(
  .SLOT_W(SLOT_W), .FINE_W(FINE_W)) u_asserts (
  .clk_sys(clk_sys), .srst(srst), .req(req), .rdata(rdata),
  .irq_events(irq_events), .slot_counter_value(slot_counter_value),
  .microsecond_counter_value(microsecond_counter_value),
  .irq_raw(irq_raw), .irq(irq), .link_cfg(link_cfg));
`default_nettype wire

// file: tb/tb_radio_core_irq_time_addr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "radio_regs_cfg.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_total++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_radio_core_irq_time_addr_regs;
  logic                      clk_sys = 1'b0;
  logic                      srst = 1'b1;
  radio_regs_pkg::reg_req_t  req = 66'h0;
  logic [31:0]               rdata;
  radio_regs_pkg::irq_vec_t  irq_events = 10'h000;
  logic [26:0]               slot_cnt = 27'h0;
  logic [9:0]                fine_cnt = 10'h000;
  radio_regs_pkg::irq_vec_t  irq_raw;
  logic                      irq;
  radio_regs_pkg::link_cfg_t link_cfg;
  int                        err_total = 0;
  int                        check_count = 0;
  radio_core_irq_time_addr_regs dut (
    .clk_sys(clk_sys), .srst(srst), .req(req), .rdata(rdata),
    .irq_events(irq_events), .slot_counter_value(slot_cnt),
    .microsecond_counter_value(fine_cnt), .irq_raw(irq_raw),
    .irq(irq), .link_cfg(link_cfg));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------
  // Bus tasks and scenarios
  // ----------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= {a, d, 2'b10};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    req <= {a, 32'h0000_0000, 2'b01};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  task automatic t_flags;
    logic [9:0] b;
    for (int i = 0; i < 10; i++) begin
      b = 10'h001 << i;
      @(posedge clk_sys);
      irq_events <= b;
      @(posedge clk_sys);
      irq_events <= 10'h000;
      wr(`OFS_IRQ_ACK, 32'h0000_0000);
      rd(`OFS_IRQ_RAW, {22'h000000, b});
      rd(`OFS_IRQ_MASKED, {22'h000000, b & 10'h11F});
      `CHK("irq_raw", b, irq_raw)
      `CHK("irq", |(b & 10'h11F), irq)
      wr(`OFS_IRQ_ACK, {22'h000000, b});
      rd(`OFS_IRQ_RAW, 32'h0000_0000);
      `CHK("irq", 1'b0, irq)
    end
    $display("flag set and acknowledge test done");
  endtask
  task automatic t_race;
    @(posedge clk_sys);
    req <= {`OFS_IRQ_ACK, 32'h0000_0020, 2'b10};
    irq_events <= 10'h020;
    @(posedge clk_sys);
    req.wr <= 1'b0;
    irq_events <= 10'h000;
    rd(`OFS_IRQ_RAW, 32'h0000_0020);
    wr(`OFS_IRQ_ACK, 32'h0000_0020);
    rd(`OFS_IRQ_ACK, 32'h0000_0000);
    rd(`OFS_IRQ_RAW, 32'h0000_0000);
    $display("set beats clear test done");
  endtask
  task automatic t_snap;
    @(posedge clk_sys);
    slot_cnt <= 27'h5A5_A5A5;
    fine_cnt <= 10'h3C5;
    wr(`OFS_CONTROL, 32'h0000_0001);
    slot_cnt <= 27'h000_0123;
    fine_cnt <= 10'h01E;
    rd(`OFS_BASE_SNAP, 32'h05A5_A5A5);
    rd(`OFS_FINE_SNAP, 32'h0000_03C5);
    wr(`OFS_CONTROL, 32'h0000_0001);
    rd(`OFS_FINE_SNAP, 32'h0000_001E);
    $display("counter snapshot test done");
  endtask
  task automatic t_addr;
    rd(`OFS_ADDR_HIGH, 32'h0000_0000);
    wr(`OFS_ADDR_LOW, 32'hA5C3_0FF1);
    wr(`OFS_ADDR_HIGH, 32'hFFFF_FFFF);
    wr(`OFS_DESC_PTRS, 32'hFFFF_FFFF);
    wr(32'h4000_0004, 32'hFFFF_FFFF);
    rd(32'h4000_0004, 32'h0000_0000);
    rd(`OFS_ADDR_LOW, 32'hA5C3_0FF1);
    rd(`OFS_ADDR_HIGH, 32'h0001_FFFF);
    rd(`OFS_DESC_PTRS, 32'hFFFF_7FFF);
    `CHK("addr", 48'hFFFF_A5C3_0FF1, link_cfg.device_addr)
    `CHK("xchg", 16'hFFFF, link_cfg.exchange_table_start)
    wr(`OFS_ADDR_HIGH, 32'h0000_0000);
    rd(`OFS_ADDR_HIGH, 32'h0000_0000);
    `CHK("private", 1'b0, link_cfg.private_address_flag)
    $display("address and pointer test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    rd(`OFS_IRQ_MASK, 32'h0000_011F);
    t_flags;
    t_race;
    t_snap;
    t_addr;
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    report_and_stop;
  end
endmodule
`default_nettype wire
